// >>> nvsram_host_cfg.svh
// Purpose: constants for the nonvolatile SRAM host controller
// Assumes: 10 MHz clock, x16 part, dual chip select
// Notes:   timing figures are in ns; cycle counts derive from them
// Operation
// - reads one to three of every sequence use 0x4E38, 0xB1C7, 0x83E0.
// - reads four and five use 0x7C1F then 0x703F, normal data returned.
// - steer by chip select or output strobe; write strobe high all six reads.
// - the six addresses are consecutive accesses in exactly the listed order.
// - after sleep request goes high the host waits the wake delay.
`ifndef NVSRAM_HOST_CFG_SVH
`define NVSRAM_HOST_CFG_SVH
`define ADDR_W            20
`define DATA_W            16
`define SEQ_ADDR_1        20'h04E38
`define SEQ_ADDR_2        20'h0B1C7
`define SEQ_ADDR_3        20'h083E0
`define SEQ_ADDR_4        20'h07C1F
`define SEQ_ADDR_5        20'h0703F
`define CMD_STORE         20'h08FC0
`define CMD_RECALL        20'h04C63
`define CMD_AUTO_OFF      20'h08B45
`define CMD_AUTO_ON       20'h04B46
`define CLK_PERIOD_NS     100
`define ACCESS_TIME_NS    200
`define STORE_CYCLE_NS    8000000
`define RECALL_CYCLE_NS   600000
`define WAKE_DELAY_NS     20000000
`define SLEEP_ENTRY_NS    8000000
`define CNT_W             24
`define NS_TO_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC        `NS_TO_CYC(`ACCESS_TIME_NS)
`define SEQ_LEN           3'h6
`endif

// >>> nvsram_host_pkg.sv
// Purpose: types shared by the nonvolatile SRAM host controller
// Assumes: constants from nvsram_host_cfg.svh
// Notes:   none
`include "nvsram_host_cfg.svh"
package nvsram_host_pkg;
    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_STORE  = 3'h2,
        OP_RECALL = 3'h3,
        OP_AUTO_OFF = 3'h4,
        OP_AUTO_ON  = 3'h5
    } op_e;
    typedef struct packed {
        op_e                    op;
        logic [`ADDR_W-1:0]     addr;
        logic [`DATA_W-1:0]     wdata;
    } host_req_s;
    typedef struct packed {
        logic                   cs_first_n;
        logic                   cs_second;
        logic                   oe_n;
        logic                   we_n;
        logic                   low_byte_select_n;
        logic                   high_byte_select_n;
        logic [`ADDR_W-1:0]     addr;
    } mem_pins_s;
endpackage

// >>> nvsram_host_timer.sv
// Purpose: down counter for long waits of the host controller
// Assumes: load has priority over counting
// Notes:   done is high while the count stands at zero and no load is applied
`timescale 1ns/1ps
`include "nvsram_host_cfg.svh"
module nvsram_host_timer (
    // clock, reset, enable
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               en_i,
    // control
    input  wire logic               load_i,
    input  wire logic [`CNT_W-1:0]  value_i,
    output logic                    done_o
);
    logic [`CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else if (en_i) begin
            if (load_i) begin
                cnt_q <= value_i;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign done_o = (cnt_q == '0) && !load_i;
endmodule

// >>> nvsram_host_ctrl.sv
// Purpose: host controller driving a nonvolatile SRAM over its asynchronous pins
// Assumes: device pins are synchronous to clk_i; one access per read or write request, six per command
// Notes:   commands run the six-read sequence without interruption
`timescale 1ns/1ps
`include "nvsram_host_cfg.svh"
module nvsram_host_ctrl
    import nvsram_host_pkg::*;
#(
    parameter logic [`CNT_W-1:0] STORE_CYC  = `CNT_W'(`NS_TO_CYC(`STORE_CYCLE_NS)),
    parameter logic [`CNT_W-1:0] RECALL_CYC = `CNT_W'(`NS_TO_CYC(`RECALL_CYCLE_NS)),
    parameter logic [`CNT_W-1:0] WAKE_CYC   = `CNT_W'(`NS_TO_CYC(`WAKE_DELAY_NS)),
    parameter logic [`CNT_W-1:0] SLEEP_CYC  = `CNT_W'(`NS_TO_CYC(`SLEEP_ENTRY_NS))
) (
    // clock, reset, enable
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               en_i,
    // user request
    input  wire logic               req_valid_i,
    input  wire host_req_s          req_i,
    output logic                    req_ready_o,
    output logic                    rsp_valid_o,
    output logic [`DATA_W-1:0]      rsp_data_o,
    // sleep control
    input  wire logic               sleep_i,
    output logic                    awake_o,
    // device pins
    output mem_pins_s               pins_o,
    output logic                    sleep_request_n_o,
    input  wire logic               store_busy_n_i,
    input  wire logic [`DATA_W-1:0] dq_i,
    output logic [`DATA_W-1:0]      dq_o,
    output logic                    dq_oe_o
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ACC   = 3'h1,
        ST_GAP   = 3'h2,
        ST_WAIT  = 3'h3,
        ST_SLEEP = 3'h4,
        ST_WAKE  = 3'h5
    } state_e;

    state_e                 state_q;
    host_req_s              cur_q;
    logic [2:0]             step_q;
    logic [2:0]             acc_cnt_q;
    mem_pins_s              pins_q;
    logic [`DATA_W-1:0]     dq_q;
    logic                   dq_oe_q;
    logic                   sleep_n_q;
    logic [`DATA_W-1:0]     rsp_data_q;
    logic                   rsp_valid_q;
    logic                   tmr_load;
    logic [`CNT_W-1:0]      tmr_value;
    logic                   tmr_done;
    logic                   last_step;

    ////////////////////////////////////////////////////////////////////////////
    // sequence address for each step; unused address bits held at zero
    function automatic logic [`ADDR_W-1:0] seq_addr(input logic [2:0] step, input op_e op);
        case (step)
            3'h0:    seq_addr = `SEQ_ADDR_1;
            3'h1:    seq_addr = `SEQ_ADDR_2;
            3'h2:    seq_addr = `SEQ_ADDR_3;
            3'h3:    seq_addr = `SEQ_ADDR_4;
            3'h4:    seq_addr = `SEQ_ADDR_5;
            default: begin
                case (op)
                    OP_STORE:    seq_addr = `CMD_STORE;
                    OP_RECALL:   seq_addr = `CMD_RECALL;
                    OP_AUTO_OFF: seq_addr = `CMD_AUTO_OFF;
                    default:     seq_addr = `CMD_AUTO_ON;
                endcase
            end
        endcase
    endfunction

    function automatic logic is_cmd(input op_e op);
        is_cmd = (op != OP_READ) && (op != OP_WRITE);
    endfunction

    assign last_step = (step_q == `SEQ_LEN - 3'h1);

    ////////////////////////////////////////////////////////////////////////////
    // long waits: store, recall, wake-up; sleep entry loads SLEEP_CYC but ST_SLEEP never waits on it
    always_comb begin
        tmr_load  = 1'b0;
        tmr_value = '0;
        if (state_q == ST_GAP && is_cmd(cur_q.op) && last_step) begin
            tmr_load  = 1'b1;
            // a store or recall is awaited in full; mode commands load zero and leave ST_WAIT after one cycle
            tmr_value = (cur_q.op == OP_STORE)  ? STORE_CYC :
                        (cur_q.op == OP_RECALL) ? RECALL_CYC :
                        '0;
        end else if (state_q == ST_IDLE && sleep_i) begin
            tmr_load  = 1'b1;
            tmr_value = SLEEP_CYC;
        end else if (state_q == ST_SLEEP && !sleep_i) begin
            tmr_load  = 1'b1;
            tmr_value = WAKE_CYC;
        end
    end

    nvsram_host_timer u_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .en_i    (en_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .done_o  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // main sequencer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q   <= ST_IDLE;
            cur_q     <= '0;
            step_q    <= 3'h0;
            acc_cnt_q <= 3'h0;
        end else if (en_i) begin
            case (state_q)
                ST_IDLE: begin
                    acc_cnt_q <= 3'h0;
                    step_q    <= 3'h0;
                    if (sleep_i) begin
                        state_q <= ST_SLEEP;
                    end else if (req_valid_i && store_busy_n_i) begin
                        cur_q   <= req_i;
                        state_q <= ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (acc_cnt_q == 3'(`ACCESS_CYC - 1)) begin
                        state_q <= ST_GAP;
                    end else begin
                        acc_cnt_q <= acc_cnt_q + 3'h1;
                    end
                end
                ST_GAP: begin
                    acc_cnt_q <= 3'h0;
                    // nothing else is issued between sequence reads
                    if (is_cmd(cur_q.op) && !last_step) begin
                        step_q  <= step_q + 3'h1;
                        state_q <= ST_ACC;
                    end else if (is_cmd(cur_q.op)) begin
                        state_q <= ST_WAIT;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    // busy pin low means store in progress; timer covers recall too
                    if (tmr_done && store_busy_n_i) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SLEEP: begin
                    if (!sleep_i) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (tmr_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // device pins, registered
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_q  <= '{cs_first_n: 1'b1, cs_second: 1'b0, oe_n: 1'b1, we_n: 1'b1,
                         low_byte_select_n: 1'b1, high_byte_select_n: 1'b1, addr: '0};
            dq_q    <= '0;
            dq_oe_q <= 1'b0;
        end else if (en_i) begin
            // select drops in every gap, so each sequence read is select-controlled
            if (state_q == ST_ACC) begin
                pins_q.cs_first_n <= 1'b0;
                pins_q.cs_second  <= 1'b1;
                pins_q.low_byte_select_n  <= 1'b0;
                pins_q.high_byte_select_n <= 1'b0;
                if (is_cmd(cur_q.op)) begin
                    pins_q.addr <= seq_addr(step_q, cur_q.op);
                    pins_q.oe_n <= 1'b0;
                    pins_q.we_n <= 1'b1;
                    dq_oe_q     <= 1'b0;
                end else begin
                    pins_q.addr <= cur_q.addr;
                    pins_q.oe_n <= (cur_q.op == OP_WRITE);
                    pins_q.we_n <= (cur_q.op != OP_WRITE);
                    dq_q        <= cur_q.wdata;
                    dq_oe_q     <= (cur_q.op == OP_WRITE);
                end
            end else begin
                // deselect between accesses so each read is its own cycle
                pins_q.cs_first_n <= 1'b1;
                pins_q.cs_second  <= 1'b0;
                pins_q.oe_n       <= 1'b1;
                pins_q.we_n       <= 1'b1;
                pins_q.low_byte_select_n  <= 1'b1;
                pins_q.high_byte_select_n <= 1'b1;
                dq_oe_q           <= 1'b0;
            end
        end
    end

    // sleep pin; during sleep every other pin is left idle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_n_q <= 1'b1;
        end else if (en_i) begin
            sleep_n_q <= !(state_q == ST_SLEEP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data capture at the end of a plain read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_data_q  <= '0;
            rsp_valid_q <= 1'b0;
        end else if (en_i) begin
            rsp_valid_q <= 1'b0;
            if (state_q == ST_GAP && cur_q.op == OP_READ) begin
                rsp_data_q  <= dq_i;
                rsp_valid_q <= 1'b1;
            end else if (state_q == ST_GAP && is_cmd(cur_q.op) && last_step) begin
                rsp_valid_q <= 1'b1; // command accepted; sixth read data is not valid
            end
        end
    end

    assign req_ready_o       = en_i && state_q == ST_IDLE && !sleep_i && store_busy_n_i;
    assign rsp_valid_o       = rsp_valid_q;
    assign rsp_data_o        = rsp_data_q;
    assign awake_o           = (state_q != ST_SLEEP) && (state_q != ST_WAKE);
    assign pins_o            = pins_q;
    assign sleep_request_n_o = sleep_n_q;
    assign dq_o              = dq_q;
    assign dq_oe_o           = dq_oe_q;
endmodule

// >>> nvsram_dev_model.sv
// Purpose: behavioural nonvolatile SRAM on the host pins
// Assumes: 16 words decoded from addr[3:0]; counts in clock cycles
// Notes: recall clear and load collapse into one load
`timescale 1ns/1ps
`include "nvsram_host_cfg.svh"
module nvsram_dev_model
    import nvsram_host_pkg::*;
#(
    parameter int BUSY_CYC = 8,
    parameter int REC_CYC  = 4
) (
    // clock
    input  wire logic               clk_i,
    // host pins
    input  wire mem_pins_s          pins_i,
    input  wire logic               sleep_request_n_i,
    input  wire logic [`DATA_W-1:0] dq_i,
    // answers
    output logic                    store_busy_n_o,
    output logic [`DATA_W-1:0]      dq_o
);
    localparam logic [19:0] SEQ [5] = '{`SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3,
                                        `SEQ_ADDR_4, `SEQ_ADDR_5};
    logic [`DATA_W-1:0] sram [16] = '{default: '0};
    logic [`DATA_W-1:0] nv   [16] = '{default: '0};
    logic [`DATA_W-1:0] last_q    = 16'hA5A5;
    logic [2:0]         step_q    = 3'h0;
    int                 cnt_q     = 0;
    logic               st_q      = 1'b0;
    logic               sel_q     = 1'b0;
    // starts low so a pin held low at power-up is never taken as sleep entry
    logic               slp_q     = 1'b0;
    logic               dirty_q   = 1'b0;
    logic               auto_q    = 1'b1;
    logic               sel;
    logic               go;
    logic               hi_z;
    function automatic logic hit(logic [19:0] a, logic [19:0] c);
        return a[14:2] == c[14:2];
    endfunction
    // sixth read of a store or recall returns no data
    assign hi_z = step_q == 3'h5 && (hit(pins_i.addr, `CMD_STORE) || hit(pins_i.addr, `CMD_RECALL));
    assign sel = !pins_i.cs_first_n && pins_i.cs_second;
    assign go = sel && !sel_q && cnt_q == 0 && sleep_request_n_i;
    assign store_busy_n_o = !(st_q && cnt_q != 0);
    // idle bus toggles so a stale word never reads back
    assign dq_o = (go || (sel && sel_q)) && !pins_i.oe_n && cnt_q == 0 && sleep_request_n_i && !hi_z
                  ? sram[pins_i.addr[3:0]] : last_q;
    always @(posedge clk_i) begin
        sel_q <= sel;
        slp_q <= sleep_request_n_i;
        last_q <= ~last_q;
        if (cnt_q != 0) cnt_q <= cnt_q - 1;
        if (!sleep_request_n_i) step_q <= 3'h0;
        if (slp_q && !sleep_request_n_i && dirty_q) begin
            nv <= sram;
            dirty_q <= 1'b0;
            st_q <= 1'b1;
            cnt_q <= BUSY_CYC;
        end
        if (go && !pins_i.we_n) begin
            sram[pins_i.addr[3:0]] <= dq_i;
            dirty_q <= 1'b1;
            step_q <= 3'h0;
        end else if (go && step_q < 3'h5) begin
            step_q <= hit(pins_i.addr, SEQ[step_q]) ? step_q + 3'h1 : 3'h0;
        end else if (go) begin
            step_q <= 3'h0;
            if (hit(pins_i.addr, `CMD_STORE)) begin
                nv <= sram;
                dirty_q <= 1'b0;
                st_q <= 1'b1;
                cnt_q <= BUSY_CYC;
            end else if (hit(pins_i.addr, `CMD_RECALL)) begin
                sram <= nv;
                dirty_q <= 1'b0;
                st_q <= 1'b0;
                cnt_q <= REC_CYC;
            end
            if (hit(pins_i.addr, `CMD_AUTO_OFF)) auto_q <= 1'b0;
            if (hit(pins_i.addr, `CMD_AUTO_ON)) auto_q <= 1'b1;
        end
    end
endmodule

// >>> nvsram_host_ctrl_sva.sv
// Purpose: port checker of the host controller
// Assumes: long counts set to 8 cycles
// Notes: an access holds the select two cycles, then one gap
`timescale 1ns/1ps
`include "nvsram_host_cfg.svh"
module nvsram_host_ctrl_chk
    import nvsram_host_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // watched ports
    input  wire logic       req_valid_i,
    input  wire host_req_s  req_i,
    input  wire logic       req_ready_o,
    input  wire logic       rsp_valid_o,
    input  wire mem_pins_s  pins_o,
    input  wire logic       sleep_request_n_o,
    input  wire logic       store_busy_n_i,
    input  wire logic       dq_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic take;
    logic cmd;
    assign take = req_valid_i && req_ready_o;
    assign cmd = take && req_i.op >= OP_STORE;
    function automatic logic at(mem_pins_s p, logic [19:0] a);
        return !p.cs_first_n && !p.oe_n && p.we_n && p.addr == a;
    endfunction
    function automatic logic [19:0] last_a(op_e o);
        case (o)
            OP_STORE:    return `CMD_STORE;
            OP_RECALL:   return `CMD_RECALL;
            OP_AUTO_OFF: return `CMD_AUTO_OFF;
            default:     return `CMD_AUTO_ON;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    property p_cmd_seq;
        cmd |-> ##2 at(pins_o, `SEQ_ADDR_1) ##3 at(pins_o, `SEQ_ADDR_2)
            ##3 at(pins_o, `SEQ_ADDR_3) ##3 at(pins_o, `SEQ_ADDR_4)
            ##3 at(pins_o, `SEQ_ADDR_5) ##3 at(pins_o, last_a($past(req_i.op, 17)));
    endproperty
    a_cmd_seq: assert property (p_cmd_seq)
        else $error("command address sequence wrong");
    property p_sel_enc;
        pins_o.cs_first_n != pins_o.cs_second;
    endproperty
    a_sel_enc: assert property (p_sel_enc)
        else $error("chip selects disagree");
    property p_busy;
        !store_busy_n_i |-> !req_ready_o;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready while device busy");
    property p_sleep;
        !sleep_request_n_o |-> !req_ready_o && pins_o.cs_first_n && !dq_oe_o;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("access while asleep");
    property p_wake;
        $rose(sleep_request_n_o) |-> !req_ready_o [*8];
    endproperty
    a_wake: assert property (p_wake)
        else $error("ready before wake delay");
    property p_cmd_nowe;
        cmd |=> ##1 (pins_o.we_n && !dq_oe_o) [*8];
    endproperty
    a_cmd_nowe: assert property (p_cmd_nowe)
        else $error("write strobe inside command");
    property p_one_req;
        take |=> !req_ready_o;
    endproperty
    a_one_req: assert property (p_one_req)
        else $error("second request accepted");
    property p_cmd_rsp;
        cmd |-> ##[19:20] rsp_valid_o;
    endproperty
    a_cmd_rsp: assert property (p_cmd_rsp)
        else $error("command not completed");
    c_store: cover property (cmd && req_i.op == OP_STORE);
    c_sleep: cover property (!sleep_request_n_o);
    c_busy: cover property (!store_busy_n_i && req_valid_i);
endmodule
bind nvsram_host_ctrl nvsram_host_ctrl_chk chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .pins_o(pins_o), .sleep_request_n_o(sleep_request_n_o),
    .store_busy_n_i(store_busy_n_i), .dq_oe_o(dq_oe_o));

// >>> nvsram_soft_sequence_sleep_ctrl_tb.sv
// Purpose: self-checking bench of the host controller
// Assumes: counts shortened to 8 cycles; inputs change on falling edge
// Notes: device state is read from the model for store checks
`timescale 1ns/1ps
`include "nvsram_host_cfg.svh"
module nvsram_soft_sequence_sleep_ctrl_tb import nvsram_host_pkg::*;;
    logic               clk;
    logic               rst_b;
    logic               en;
    logic               req_valid;
    logic               ready;
    logic               rsp_valid;
    logic               sleep;
    logic               awake;
    logic               slp_n;
    logic               busy_n;
    logic               dq_oe;
    host_req_s          req;
    mem_pins_s          pins;
    logic [`DATA_W-1:0] rsp_data;
    logic [`DATA_W-1:0] dq_dev;
    logic [`DATA_W-1:0] dq_host;
    logic [`DATA_W-1:0] rd;
    int                 err_total = 0;
    int                 comparisons = 0;
    typedef struct packed { host_req_s r; logic [15:0] exp; } row_s;
    localparam row_s ROWS [4] = '{'{'{OP_WRITE, 20'h00001, 16'h1234}, 16'h0000},
        '{'{OP_WRITE, 20'h00002, 16'hABCD}, 16'h0000},
        '{'{OP_READ, 20'h00001, 16'h0000}, 16'h1234},
        '{'{OP_READ, 20'h00002, 16'h0000}, 16'hABCD}};
    nvsram_host_ctrl #(.STORE_CYC(24'h000008), .RECALL_CYC(24'h000008),
        .WAKE_CYC(24'h000008), .SLEEP_CYC(24'h000008)) dut (.clk_i(clk), .rst_b_i(rst_b),
        .en_i(en), .req_valid_i(req_valid), .req_i(req), .req_ready_o(ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .sleep_i(sleep), .awake_o(awake),
        .pins_o(pins), .sleep_request_n_o(slp_n), .store_busy_n_i(busy_n), .dq_i(dq_dev),
        .dq_o(dq_host), .dq_oe_o(dq_oe));
    nvsram_dev_model mdl (.clk_i(clk), .pins_i(pins), .sleep_request_n_i(slp_n),
        .dq_i(dq_host), .store_busy_n_o(busy_n), .dq_o(dq_dev));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // a wait that runs out ends the run as a failure
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            err_total++;
            test_done();
        end
    endtask
    task automatic issue(input op_e op, input logic [19:0] a, input logic [15:0] d);
        wait_for(ready, 1'b1);
        req_valid = 1'b1;
        req = '{op, a, d};
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        if (op != OP_WRITE) wait_for(rsp_valid, 1'b1);
        rd = rsp_data;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        sleep = 1'b0;
        repeat (4) @(negedge clk);
        check("select in reset", 16'h0001, pins.cs_first_n);
        check("sleep pin in reset", 16'h0001, slp_n);
        rst_b = 1'b1;
        foreach (ROWS[i]) begin
            issue(ROWS[i].r.op, ROWS[i].r.addr, ROWS[i].r.wdata);
            if (ROWS[i].r.op == OP_READ) check("row read", ROWS[i].exp, rd);
        end
        en = 1'b0;
        repeat (2) @(negedge clk);
        check("ready frozen", 16'h0000, ready);
        en = 1'b1;
        issue(OP_STORE, 20'h00000, 16'h0000);
        check("read data over store", 16'hABCD, rd);
        check("busy pin in store", 16'h0000, busy_n);
        check("ready in store", 16'h0000, ready);
        check("stored word", 16'h1234, mdl.nv[1]);
        issue(OP_WRITE, 20'h00001, 16'hFFFF);
        issue(OP_RECALL, 20'h00000, 16'h0000);
        check("nonvolatile kept", 16'h1234, mdl.nv[1]);
        issue(OP_READ, 20'h00001, 16'h0000);
        check("recalled word", 16'h1234, rd);
        issue(OP_AUTO_OFF, 20'h00000, 16'h0000);
        check("auto save off", 16'h0000, mdl.auto_q);
        issue(OP_AUTO_ON, 20'h00000, 16'h0000);
        check("auto save on", 16'h0001, mdl.auto_q);
        issue(OP_WRITE, 20'h00002, 16'h2222);
        sleep = 1'b1;
        wait_for(slp_n, 1'b0);
        check("ready asleep", 16'h0000, ready);
        check("awake asleep", 16'h0000, awake);
        wait_for(busy_n, 1'b0);
        wait_for(busy_n, 1'b1);
        check("sleep store", 16'h2222, mdl.nv[2]);
        sleep = 1'b0;
        wait_for(slp_n, 1'b1);
        repeat (2) @(negedge clk);
        check("ready waking", 16'h0000, ready);
        check("awake waking", 16'h0000, awake);
        issue(OP_READ, 20'h00002, 16'h0000);
        check("read after wake", 16'h2222, rd);
        check("awake after wake", 16'h0001, awake);
        sleep = 1'b1;
        wait_for(slp_n, 1'b0);
        repeat (2) @(negedge clk);
        check("no store when clean", 16'h0001, busy_n);
        sleep = 1'b0;
        wait_for(slp_n, 1'b1);
        test_done();
    end
endmodule
